/* File: rtl/tmb_pkg.sv */
package tmb_pkg;
   // Register byte addresses
   localparam logic [19:0] TMB_IRQ_ADDR      = 20'h4_0004;
   localparam logic [19:0] TMB_CLK_ADDR      = 20'h4_0308;
   localparam logic [19:0] TMB_PORT_ADDR     = 20'h4_0840;
   localparam logic [19:0] TMB_CTRL_ADDR     = 20'h4_0C04;
   localparam logic [19:0] TMB_COUNT_ADDR    = 20'h4_0C08;
   localparam logic [19:0] TMB_THRESH_ADDR   = 20'h4_0C0C;
   localparam logic [19:0] TMB_DUTY_ADDR     = 20'h4_0C10;

   // Control register fields
   localparam int TMB_TRIG_LSB    = 0;
   localparam int TMB_CMODE_LSB   = 2;
   localparam int TMB_CLEAR_BIT   = 4;
   localparam int TMB_ENABLE_BIT  = 5;
   localparam int TMB_CH0_MODE_LSB = 16;
   localparam int TMB_CH0_PHASE_BIT = 19;
   localparam int TMB_CH1_MODE_LSB = 20;
   localparam int TMB_CH1_PHASE_BIT = 23;

   // Interrupt register fields
   localparam int TMB_OVF_FLAG_BIT = 1;
   localparam int TMB_OVF_IE_BIT   = 17;

   // Port control fields
   localparam int TMB_PIN0_OE_BIT  = 0;
   localparam int TMB_PIN1_OE_BIT  = 1;
   localparam int TMB_ROUTE_LSB    = 2;

   // Clock control fields
   localparam int TMB_DIV_LSB      = 4;
   localparam int TMB_SRC_LSB      = 6;

   // Reset values
   localparam logic [15:0] TMB_THRESH_RESET = 16'hFFFF;
   localparam logic [31:0] TMB_DUTY_RESET   = 32'hFFFF_FFFF;

   // Count modes
   localparam logic [1:0] TMB_CM_UP16     = 2'h0;
   localparam logic [1:0] TMB_CM_UPDOWN16 = 2'h1;
   localparam logic [1:0] TMB_CM_SPLIT8   = 2'h2;
   localparam logic [1:0] TMB_CM_CASCADE8 = 2'h3;

   // Trigger selections
   localparam logic [1:0] TMB_TRIG_ALWAYS = 2'h0;
   localparam logic [1:0] TMB_TRIG_EXT    = 2'h3;

   // Clock source selection
   localparam logic [1:0] TMB_SRC_HIGH    = 2'h0;

   // Waveform modes
   localparam logic [2:0] TMB_WM_GE_FIRST   = 3'h0;
   localparam logic [2:0] TMB_WM_GE_SECOND  = 3'h1;
   localparam logic [2:0] TMB_WM_LOW_FIRST  = 3'h2;
   localparam logic [2:0] TMB_WM_HIGH_SECOND = 3'h3;
   localparam logic [2:0] TMB_WM_DITHER     = 3'h4;
   localparam logic [2:0] TMB_WM_WINDOW     = 3'h5;
endpackage

/* File: rtl/tmb_pwm_chan.sv */
`timescale 1ns/1ps
module tmb_pwm_chan
   import tmb_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        run,
   input  wire logic        tick,
   input  wire logic        ovf,
   input  wire logic [2:0]  wave_mode,
   input  wire logic        phase,
   input  wire logic [15:0] cnt,
   input  wire logic [15:0] thr,
   input  wire logic [15:0] cmp_first,
   input  wire logic [15:0] cmp_second,
   output logic             pin_level
);
   logic       wave;
   logic       next_wave;
   logic [2:0] lsb_idx;
   logic       dither_plus;
   logic [8:0] dither_point;
   logic       dither_on;

   // Position of lowest set bit in the overflow index
   function automatic logic [2:0] lowest_one(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   assign lsb_idx      = lowest_one(cnt[15:8]);
   assign dither_plus  = (cnt[15:8] != 8'h00) && cmp_second[lsb_idx]; // [RULE9] [RULE10] [RULE11] [RULE22]
   assign dither_point = {1'b0, cmp_first[7:0]} + {8'h00, dither_plus}; // [RULE4]
   // Level compare, so the high time spans N up to and including the threshold
   assign dither_on    = ({1'b0, cnt[7:0]} >= dither_point); // [RULE6] [RULE12]

   always_comb begin
      next_wave = wave;
      case (wave_mode)
         TMB_WM_GE_FIRST:    next_wave = (cnt >= cmp_first);
         TMB_WM_GE_SECOND:   next_wave = (cnt >= cmp_second);
         TMB_WM_LOW_FIRST:   next_wave = (cnt[7:0] >= cmp_first[7:0]);
         TMB_WM_HIGH_SECOND: next_wave = (cnt[15:8] >= cmp_second[7:0]);
         TMB_WM_DITHER:      next_wave = dither_on; // [RULE6] [RULE7]
         TMB_WM_WINDOW:      next_wave = (cnt > cmp_first) && (cnt <= cmp_second); // [RULE16]
         default: begin
            if (ovf) begin
               next_wave = ~wave; // [RULE18]
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wave <= 1'b0;
      end else if (!run) begin
         wave <= 1'b0; // [RULE5]
      end else if (tick) begin
         wave <= next_wave;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_level <= 1'b1;
      end else begin
         pin_level <= phase ? wave : ~wave; // [RULE13]
      end
   end

   wave_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE5]
      !run |=> !wave)
      else $error("wave not cleared while stopped");

   dither_top_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE7]
      (run && tick && ovf && wave_mode == TMB_WM_DITHER && cnt[7:0] == thr[7:0] && cmp_first[7:0] < thr[7:0])
      |=> wave)
      else $error("dithered wave not high at period end");

   dither_low_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE6]
      (run && tick && wave_mode == TMB_WM_DITHER && cnt[7:0] < cmp_first[7:0]) |=> !wave)
      else $error("dithered wave high below base width");

   freq_toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE18]
      (run && tick && ovf && wave_mode[2:1] == 2'b11) |=> (wave != $past(wave)))
      else $error("frequency wave did not toggle on overflow");

   phase_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE13]
      ##1 pin_level == ($past(phase) ? $past(wave) : !$past(wave)))
      else $error("pin polarity wrong");
endmodule

/* File: rtl/tmb_pwm_top.sv */
// Behaviour
// [RULE1] Count mode 11 gives cascaded 8+8 counter
// [RULE2] Wave mode 100 selects dithered waveform
// [RULE3] Trigger select 00 counts continuously
// [RULE4] Threshold low byte frequency, first compare duty
// [RULE5] Enable bit starts; clearing stops counter, outputs
// [RULE6] Output rises when low byte equals N
// [RULE7] Low byte at threshold: fall, flag, restart
// [RULE8] Interrupt request only when enable bit set
// [RULE9] Fine value picks periods using N+1
// [RULE10] Fine adjust bits add together
// [RULE11] N+1 periods spread over 256 overflows
// [RULE12] Dithered frequency and average duty formulas
// [RULE13] Phase bit: 0 inverted, 1 normal
// [RULE14] Port bits enable pins, route field
// [RULE15] Clock source select and divider
// [RULE16] Window mode high between two compares
// [RULE17] Software keeps second compare above first
// [RULE18] Frequency mode toggles, exact half duty
// [RULE19] Register map at documented addresses
// [RULE20] Counter clear bit self clears after clearing
// [RULE21] Cascade: low overflow increments high byte
// [RULE22] N+1 where fine bit at lowest index bit
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module tmb_pwm_top
   import tmb_pkg::*;
#(
   parameter int PRESCALE_W = 8
)(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [19:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        low_speed_clock,
   input  wire logic        ext_trigger,
   output logic             timer_overflow_irq,
   output logic [1:0]       pwm_pin_out,
   output logic [1:0]       pwm_pin_oe,
   output logic [2:0]       pwm_pin_route_select
);
   // Software state
   logic [7:0]  ctrl_lo;
   logic [7:0]  ctrl_hi;
   logic [15:0] period_threshold;
   logic [15:0] duty_compare_first;
   logic [15:0] duty_compare_second;
   logic        timer_overflow_flag;
   logic        timer_overflow_irq_enable;
   logic [4:0]  port_ctrl;
   logic [3:0]  clk_ctrl;

   // Timer state
   logic [15:0]          timer_count_value;
   logic                 count_down;
   logic [PRESCALE_W-1:0] prescale;
   logic                 ls_sync1;
   logic                 ls_sync2;
   logic                 ls_prev;
   logic                 trig_sync1;
   logic                 trig_sync2;

   // Decoded fields
   logic [1:0] count_trigger_select;
   logic [1:0] count_mode_select;
   logic       counter_clear_bit;
   logic       timer_enable_bit;
   logic [2:0] ch0_wave_mode;
   logic [2:0] ch1_wave_mode;
   logic       ch0_phase_select;
   logic       ch1_phase_select;
   logic [1:0] timer_clock_source_select;
   logic [1:0] timer_clock_divider;

   assign count_trigger_select      = ctrl_lo[TMB_TRIG_LSB +: 2];
   assign count_mode_select         = ctrl_lo[TMB_CMODE_LSB +: 2];
   assign counter_clear_bit         = ctrl_lo[TMB_CLEAR_BIT];
   assign timer_enable_bit          = ctrl_lo[TMB_ENABLE_BIT];
   assign ch0_wave_mode             = ctrl_hi[TMB_CH0_MODE_LSB - 16 +: 3]; // [RULE2]
   assign ch1_wave_mode             = ctrl_hi[TMB_CH1_MODE_LSB - 16 +: 3]; // [RULE2]
   assign ch0_phase_select          = ctrl_hi[TMB_CH0_PHASE_BIT - 16];
   assign ch1_phase_select          = ctrl_hi[TMB_CH1_PHASE_BIT - 16];
   assign timer_clock_source_select = clk_ctrl[TMB_SRC_LSB - TMB_DIV_LSB +: 2];
   assign timer_clock_divider       = clk_ctrl[1:0];

   // APB decode
   logic sel_irq;
   logic sel_clk;
   logic sel_port;
   logic sel_ctrl;
   logic sel_count;
   logic sel_thresh;
   logic sel_duty;
   logic mapped;
   logic setup;
   logic wr;

   assign sel_irq    = (paddr == TMB_IRQ_ADDR);
   assign sel_clk    = (paddr == TMB_CLK_ADDR);
   assign sel_port   = (paddr == TMB_PORT_ADDR);
   assign sel_ctrl   = (paddr == TMB_CTRL_ADDR); // [RULE19]
   assign sel_count  = (paddr == TMB_COUNT_ADDR); // [RULE19]
   assign sel_thresh = (paddr == TMB_THRESH_ADDR); // [RULE19]
   assign sel_duty   = (paddr == TMB_DUTY_ADDR); // [RULE19]
   assign mapped     = sel_irq | sel_clk | sel_port | sel_ctrl | sel_count | sel_thresh | sel_duty;
   assign setup      = psel & ~penable;
   assign wr         = psel & penable & pwrite;
   assign pready     = 1'b1;
   assign pslverr    = psel & penable & ~mapped;

   logic [31:0] read_mux;
   assign read_mux =
      ({32{sel_irq}}    & {14'h0000, timer_overflow_irq_enable, 15'h0000, timer_overflow_flag, 1'b0}) |
      ({32{sel_clk}}    & {24'h00_0000, clk_ctrl, 4'h0}) |
      ({32{sel_port}}   & {27'h000_0000, port_ctrl}) |
      ({32{sel_ctrl}}   & {8'h00, ctrl_hi, 8'h00, ctrl_lo}) |
      ({32{sel_count}}  & {16'h0000, timer_count_value}) |
      ({32{sel_thresh}} & {16'h0000, period_threshold}) |
      ({32{sel_duty}}   & {duty_compare_second, duty_compare_first});

   // Read data is captured in setup so the access phase answers at once
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= read_mux;
      end
   end

   // Timer clock: fast clock is ref_clk, slow clock is a synchronised pin
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ls_sync1   <= 1'b0;
         ls_sync2   <= 1'b0;
         ls_prev    <= 1'b0;
         trig_sync1 <= 1'b0;
         trig_sync2 <= 1'b0;
      end else begin
         ls_sync1   <= low_speed_clock;
         ls_sync2   <= ls_sync1;
         ls_prev    <= ls_sync2;
         trig_sync1 <= ext_trigger;
         trig_sync2 <= trig_sync1;
      end
   end

   logic src_tick;
   logic [PRESCALE_W-1:0] div_last;
   logic div_tick;
   logic trig_ok;
   logic run;
   logic tick;

   assign src_tick = (timer_clock_source_select == TMB_SRC_HIGH) ? 1'b1 : (ls_sync2 & ~ls_prev); // [RULE15]
   // Divide by 1, 2, 4 or 8
   assign div_last = PRESCALE_W'((1 << timer_clock_divider) - 1); // [RULE15]
   assign div_tick = src_tick && (prescale >= div_last);
   assign trig_ok  = (count_trigger_select == TMB_TRIG_ALWAYS) || // [RULE3]
                     ((count_trigger_select == TMB_TRIG_EXT) && trig_sync2);
   assign run      = timer_enable_bit; // [RULE5]
   assign tick     = run && div_tick && trig_ok && !counter_clear_bit;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prescale <= '0;
      end else if (!run || div_tick) begin
         prescale <= '0;
      end else if (src_tick) begin
         prescale <= prescale + PRESCALE_W'(1);
      end
   end

   // Counter
   logic        low_at_top;
   logic        high_at_top;
   logic        full_at_top;
   logic        ovf;
   logic [15:0] next_count;
   logic        next_down;

   assign low_at_top  = (timer_count_value[7:0] == period_threshold[7:0]);
   assign high_at_top = (timer_count_value[15:8] == period_threshold[15:8]);
   assign full_at_top = (timer_count_value == period_threshold);

   always_comb begin
      next_count = timer_count_value + 16'h0001;
      next_down  = count_down;
      ovf        = 1'b0;
      case (count_mode_select)
         TMB_CM_UP16: begin
            if (full_at_top) begin
               next_count = 16'h0000;
               ovf        = 1'b1;
            end
         end
         TMB_CM_UPDOWN16: begin
            if (count_down) begin
               next_count = timer_count_value - 16'h0001;
               if (timer_count_value == 16'h0001) begin
                  next_down = 1'b0;
                  ovf       = 1'b1;
               end
            end else if (full_at_top) begin
               next_count = timer_count_value - 16'h0001;
               next_down  = 1'b1;
            end
         end
         TMB_CM_SPLIT8: begin
            next_count[7:0]  = low_at_top ? 8'h00 : timer_count_value[7:0] + 8'h01;
            next_count[15:8] = high_at_top ? 8'h00 : timer_count_value[15:8] + 8'h01;
            ovf              = low_at_top;
         end
         TMB_CM_CASCADE8: begin
            if (low_at_top) begin
               next_count[7:0]  = 8'h00; // [RULE1] [RULE21] [RULE7]
               next_count[15:8] = timer_count_value[15:8] + 8'h01; // [RULE21]
               ovf              = 1'b1; // [RULE7]
            end else begin
               next_count[15:8] = timer_count_value[15:8];
               next_count[7:0]  = timer_count_value[7:0] + 8'h01;
            end
         end
         default: next_count = timer_count_value;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_count_value <= 16'h0000;
         count_down        <= 1'b0;
      end else if (counter_clear_bit) begin
         timer_count_value <= 16'h0000; // [RULE20]
         count_down        <= 1'b0;
      end else if (tick) begin
         timer_count_value <= next_count; // [RULE5]
         count_down        <= next_down;
      end
   end

   logic ovf_event;
   assign ovf_event = tick & ovf;

   // Registers written by software
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_lo <= 8'h00;
         ctrl_hi <= 8'h00;
      end else if (wr && sel_ctrl) begin
         ctrl_lo <= {2'b00, pwdata[5:0]} & 8'h3F;
         ctrl_hi <= pwdata[23:16];
      end else if (counter_clear_bit) begin
         ctrl_lo[TMB_CLEAR_BIT] <= 1'b0; // [RULE20]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         period_threshold    <= TMB_THRESH_RESET;
         duty_compare_first  <= TMB_DUTY_RESET[15:0];
         duty_compare_second <= TMB_DUTY_RESET[31:16];
         port_ctrl           <= 5'h00;
         clk_ctrl            <= 4'h0;
      end else if (wr) begin
         if (sel_thresh) begin
            period_threshold <= pwdata[15:0];
         end
         if (sel_duty) begin
            duty_compare_first  <= pwdata[15:0];
            duty_compare_second <= pwdata[31:16];
         end
         if (sel_port) begin
            port_ctrl <= pwdata[4:0];
         end
         if (sel_clk) begin
            clk_ctrl <= pwdata[7:4];
         end
      end
   end

   // Overflow flag: write one clears, a same-cycle overflow wins
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_overflow_flag       <= 1'b0;
         timer_overflow_irq_enable <= 1'b0;
      end else begin
         if (ovf_event) begin
            timer_overflow_flag <= 1'b1; // [RULE7]
         end else if (wr && sel_irq && pwdata[TMB_OVF_FLAG_BIT]) begin
            timer_overflow_flag <= 1'b0;
         end
         if (wr && sel_irq) begin
            timer_overflow_irq_enable <= pwdata[TMB_OVF_IE_BIT];
         end
      end
   end

   assign timer_overflow_irq = timer_overflow_flag & timer_overflow_irq_enable; // [RULE8]

   // Channels; the second compare must exceed the first for window mode
   logic [1:0] pin_level;
   logic [2:0] ch_mode  [2];
   logic       ch_phase [2];
   assign ch_mode[0]  = ch0_wave_mode;
   assign ch_mode[1]  = ch1_wave_mode;
   assign ch_phase[0] = ch0_phase_select;
   assign ch_phase[1] = ch1_phase_select;

   for (genvar c = 0; c < 2; c++) begin : g_chan
      tmb_pwm_chan u_chan (
         .ref_clk    (ref_clk),
         .rst_b      (rst_b),
         .run        (run),
         .tick       (tick),
         .ovf        (ovf),
         .wave_mode  (ch_mode[c]),
         .phase      (ch_phase[c]),
         .cnt        (timer_count_value),
         .thr        (period_threshold),
         .cmp_first  (duty_compare_first),
         .cmp_second (duty_compare_second),
         .pin_level  (pin_level[c])
      );
   end

   assign pwm_pin_out          = pin_level;
   assign pwm_pin_oe           = {port_ctrl[TMB_PIN1_OE_BIT], port_ctrl[TMB_PIN0_OE_BIT]}; // [RULE14]
   assign pwm_pin_route_select = port_ctrl[TMB_ROUTE_LSB +: 3]; // [RULE14]

   cascade_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE21]
      (tick && count_mode_select == TMB_CM_CASCADE8 && low_at_top && !(wr && sel_ctrl))
      |=> (timer_count_value[7:0] == 8'h00) &&
          (timer_count_value[15:8] == $past(timer_count_value[15:8]) + 8'h01))
      else $error("cascade step wrong");

   flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE7]
      ovf_event |=> timer_overflow_flag)
      else $error("overflow flag not set");

   irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE8]
      timer_overflow_irq |-> (timer_overflow_flag && timer_overflow_irq_enable))
      else $error("interrupt without enable");

   clear_self_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE20]
      (counter_clear_bit && !(wr && sel_ctrl)) |=> (timer_count_value == 16'h0000) && !counter_clear_bit)
      else $error("counter clear did not complete");

   stop_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE5]
      (!run && !counter_clear_bit) |=> $stable(timer_count_value))
      else $error("counter moved while disabled");

   pin_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [RULE14]
      (wr && sel_port) |=> (pwm_pin_oe == $past(pwdata[1:0])))
      else $error("pin enable not taken");
endmodule

/* File: tb/tmb_pin_load.sv */
`timescale 1ns/1ps
module tmb_pin_load (
   input  wire logic       ref_clk,
   input  wire logic [1:0] pwm_pin_out,
   input  wire logic [1:0] pwm_pin_oe,
   output logic      [1:0] pin_level
);
   int   hi_q[$];
   int   lo_q[$];
   int   run_len = 0;
   logic last    = 1'b0;
   // Undriven pin is held low by the load's pull-down
   assign pin_level = pwm_pin_out & pwm_pin_oe;
   // Run lengths of channel 0, one entry per level change
   always @(posedge ref_clk) begin
      if (pin_level[0] !== last) begin
         if (last) begin
            hi_q.push_back(run_len);
         end else begin
            lo_q.push_back(run_len);
         end
         run_len = 1;
      end else begin
         run_len = run_len + 1;
      end
      last = pin_level[0];
   end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench
   import tmb_pkg::*;
;
   logic        ref_clk;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [19:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        low_speed_clock;
   logic        ext_trigger;
   logic        irq;
   logic [1:0]  pin_out;
   logic [1:0]  pin_oe;
   logic [2:0]  route;
   logic [1:0]  level;
   logic [31:0] rdat;
   logic [31:0] r1;
   logic        perr;
   int          num_errors = 0;
   int          checked    = 0;
   int          cycles     = 0;
   int          seed;
   int          thr;
   int          n;
   int          fine_tab[5] = '{3, 128, 255, 133, 0};

   tmb_pwm_top dut_u (
      .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_speed_clock(low_speed_clock), .ext_trigger(ext_trigger), .timer_overflow_irq(irq),
      .pwm_pin_out(pin_out), .pwm_pin_oe(pin_oe), .pwm_pin_route_select(route)
   );
   tmb_pin_load load_u (.ref_clk(ref_clk), .pwm_pin_out(pin_out), .pwm_pin_oe(pin_oe), .pin_level(level));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Six reference cycles a period, edges never on a reference edge
   initial begin
      low_speed_clock = 1'b0;
      #7;
      forever #120 low_speed_clock = ~low_speed_clock;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) begin
         @(posedge ref_clk);
      end
      rdat = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [19:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   function automatic logic [31:0] ctrl(logic en, logic [1:0] cm, logic [2:0] m0, logic p0, logic [2:0] m1,
                                        logic p1);
      return {8'h00, p1, m1, p0, m0, 10'h000, en, 1'b0, cm, TMB_TRIG_ALWAYS};
   endfunction
   // Pulse narrows by one tick where the fine bit of index k applies
   function automatic int hi_w(int t, int b, int f, int k);
      int j;
      j = 0;
      if (k % 256 == 0) begin
         return t + 1 - b;
      end
      while (((k >> j) & 1) == 0) begin
         j++;
      end
      return t + 1 - b - ((f >> j) & 1);
   endfunction

   task automatic run(input logic [1:0] cm, input logic [2:0] md, input int t, input int c1, input int c2,
                      input int f, input int np);
      int hi;
      int per;
      wr(TMB_CTRL_ADDR, ctrl(1'b0, cm, md, 1'b1, md, 1'b0) | 32'h0000_0010);
      rd(TMB_COUNT_ADDR);
      chk(rdat, 32'h0000_0000);
      rd(TMB_CTRL_ADDR);
      chk(rdat & 32'h0000_0010, 32'h0000_0000);
      wr(TMB_THRESH_ADDR, (md == TMB_WM_DITHER) ? 32'(t) | 32'h0000_5a00 : 32'(t));
      wr(TMB_DUTY_ADDR, (32'(c2) << 16) | 32'(c1));
      load_u.hi_q.delete();
      load_u.lo_q.delete();
      wr(TMB_CTRL_ADDR, ctrl(1'b1, cm, md, 1'b1, md, 1'b0));
      while (load_u.hi_q.size() <= np) begin
         @(negedge ref_clk);
         chk({31'h0, pin_out[1]}, {31'h0, ~pin_out[0]});
      end
      per = (md[1] ? 2 : 1) * (t + 1) * f;
      for (int k = 0; k < np; k++) begin
         hi = md[1] ? (t + 1) * f : md[0] ? (c2 - c1) * f : hi_w(t, c1, c2, k) * f;
         chk(load_u.hi_q[k], hi);
         chk(load_u.lo_q[k + 1] + load_u.hi_q[k + 1], per);
      end
      if (f == 1) begin
         rd(TMB_COUNT_ADDR);
         r1 = rdat;
         rd(TMB_COUNT_ADDR);
         chk({31'h0, r1 !== rdat}, 32'h0000_0001);
      end
      wr(TMB_CTRL_ADDR, ctrl(1'b0, cm, md, 1'b1, md, 1'b0));
      rd(TMB_COUNT_ADDR);
      r1 = rdat;
      rd(TMB_COUNT_ADDR);
      chk(rdat, r1);
      chk({30'h0, level}, 32'h0000_0002);
      $display("test mode %0d divisor %0d done", md, f);
   endtask

   initial begin
      seed        = 32'h1f8f_1e3d;
      rst_b       = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 20'h0_0000;
      pwdata      = 32'h0000_0000;
      ext_trigger = 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      chk({27'h0, route, pin_oe}, 32'h0000_0000);
      rd(TMB_THRESH_ADDR);
      chk(rdat, 32'h0000_ffff);
      rd(TMB_DUTY_ADDR);
      chk(rdat, 32'hffff_ffff);
      rd(TMB_CTRL_ADDR);
      chk(rdat, 32'h0000_0000);
      rd(20'h4_0c14);
      chk({31'h0, perr}, 32'h0000_0001);
      wr(TMB_CTRL_ADDR, 32'hffff_ffff);
      rd(TMB_CTRL_ADDR);
      chk(rdat, 32'h00ff_002f);
      wr(TMB_COUNT_ADDR, 32'h0000_1234);
      rd(TMB_COUNT_ADDR);
      chk(rdat, 32'h0000_0000);
      // External gate selected above: counting starts once the pin is raised
      ext_trigger <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(TMB_COUNT_ADDR);
      chk({31'h0, rdat != 32'h0000_0000}, 32'h0000_0001);
      $display("test registers done");
      repeat (3) begin
         r1 = $random(seed);
         wr(TMB_PORT_ADDR, r1 & 32'h0000_001f);
         @(negedge ref_clk);
         chk({27'h0, route, pin_oe}, r1 & 32'h0000_001f);
      end
      wr(TMB_PORT_ADDR, 32'h0000_0003);
      fine_tab[4] = $random(seed) & 255;
      foreach (fine_tab[i]) begin
         thr = 6 + ($unsigned($random(seed)) % 10);
         n = 1 + ($unsigned($random(seed)) % (thr - 3));
         run(TMB_CM_CASCADE8, TMB_WM_DITHER, thr, n, fine_tab[i], 1, 258);
         if (i == 0) begin
            rd(TMB_IRQ_ADDR);
            chk(rdat & 32'h0000_0002, 32'h0000_0002);
            chk({31'h0, irq}, 32'h0000_0000);
            wr(TMB_IRQ_ADDR, 32'h0002_0000);
            @(negedge ref_clk);
            chk({31'h0, irq}, 32'h0000_0001);
            wr(TMB_IRQ_ADDR, 32'h0002_0002);
            @(negedge ref_clk);
            chk({31'h0, irq}, 32'h0000_0000);
            rd(TMB_IRQ_ADDR);
            chk(rdat & 32'h0002_0002, 32'h0002_0000);
            wr(TMB_IRQ_ADDR, 32'h0000_0000);
            $display("test overflow flag done");
         end
      end
      // Second compare kept above the first, as software must
      for (int dv = 0; dv < 5; dv++) begin
         wr(TMB_CLK_ADDR, (dv < 4) ? 32'(dv) << TMB_DIV_LSB : 32'h0000_0040);
         thr = 20 + ($unsigned($random(seed)) % 10);
         n = 1 + ($unsigned($random(seed)) % 8);
         run(TMB_CM_UP16, TMB_WM_WINDOW, thr, n, n + 1 + ($unsigned($random(seed)) % (thr - n)),
             (dv < 4) ? (1 << dv) : 6, 4);
      end
      wr(TMB_CLK_ADDR, 32'h0000_0000);
      run(TMB_CM_UP16, 3'h6, 5 + ($unsigned($random(seed)) % 10), 0, 0, 1, 6);
      give_verdict();
   end
endmodule
